//--- verilog/tep_timer_ports.sv
// Summary of operation
// - Measurement done gives one 0.5 us pulse
// - Measurement-done output needs no enabling
// - Relay closure gives identical 0.5 us pulse
// - Interval mode: 50 us pulses, 1 s..24 h
// - Interval pulse raises request when mask allows
// - Fast mode: 16 us pulses, n x 100 us
// - Fast pulses never raise a request
// - Fast drives output; interval keeps running
// - Interval given as BCD hours, minutes, seconds
// - First pulse one period after load, up to one tick early
// - Request re-raised each period after clearing
// - Pulses continue regardless of pending request
`timescale 1ns/1ps
`default_nettype none
module tep_timer_ports
   import tep_pkg::*;
#(
   parameter int unsigned TICK_CYCLES = TICK_CYC,
   parameter int unsigned TICKS_PER_SECOND = TICKS_PER_SEC,
   parameter int unsigned SHORT_CYCLES = SHORT_CYC,
   parameter int unsigned INTERVAL_W_CYCLES = INTERVAL_W_CYC,
   parameter int unsigned FAST_W_CYCLES = FAST_W_CYC
)
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic meas_done_evt,
   input wire logic relay_closed_evt,
   input wire tep_cmd_type cmd,
   input wire tep_hms_type interval_hms,
   input wire logic [13:0] fast_timer_cmd,
   input wire logic request_mask_set_cmd,
   input wire logic request_clear,
   output logic measurement_done_out,
   output logic relay_closed_out,
   output logic timer_out,
   output logic service_request,
   output logic interval_active,
   output logic fast_active
);

   logic [12:0] tick_cnt_reg;
   logic tick_reg;
   logic [4:0] done_cnt_reg;
   logic [4:0] relay_cnt_reg;
   logic [16:0] sec_period_reg;
   logic [16:0] sec_cnt_reg;
   logic [13:0] sub_cnt_reg;
   logic [13:0] fast_period_reg;
   logic [13:0] fast_cnt_reg;
   logic mask_reg;
   logic interval_fire;
   logic fast_fire;
   logic [11:0] iw_cnt_reg;
   logic [9:0] fw_cnt_reg;
   logic [19:0] hms_secs;
   logic hms_digits_ok;

   // Counter widths bound what the parameters may ask for
   if (TICK_CYCLES < 2 || TICK_CYCLES > 8192) begin : g_bad_tick
      $error("tick length does not fit its counter");
   end
   if (TICKS_PER_SECOND < 1 || TICKS_PER_SECOND > 16384) begin : g_bad_sec
      $error("ticks per second do not fit their counter");
   end
   if (SHORT_CYCLES < 1 || SHORT_CYCLES > 31) begin : g_bad_short
      $error("short pulse does not fit its counter");
   end
   if (INTERVAL_W_CYCLES < 1 || INTERVAL_W_CYCLES > 4095) begin : g_bad_iw
      $error("interval pulse does not fit its counter");
   end
   // Fast pulse must end before the shortest fast period
   if (FAST_W_CYCLES < 1 || FAST_W_CYCLES >= TICK_CYCLES ||
      FAST_W_CYCLES > 1023) begin : g_bad_fw
      $error("fast pulse does not fit its period");
   end

   // BCD to seconds; short forms arrive with leading fields zero
   function automatic logic [19:0] bcd2(input logic [7:0] b);
      bcd2 = 20'(b[7:4]) * 20'h0000A + 20'(b[3:0]);
   endfunction

   // A nibble above nine is no decimal digit
   function automatic logic bcd_ok(input logic [7:0] b);
      bcd_ok = b[7:4] <= 4'h9 && b[3:0] <= 4'h9;
   endfunction

   // Wide enough for 99 h, so a big entry cannot wrap into range
   assign hms_secs = bcd2(interval_hms.hours) * 20'h00E10 +
      bcd2(interval_hms.minutes) * 20'h0003C +
      bcd2(interval_hms.seconds);
   assign hms_digits_ok = bcd_ok(interval_hms.hours) &&
      bcd_ok(interval_hms.minutes) &&
      bcd_ok(interval_hms.seconds);

   // Shared 100 us tick
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         tick_cnt_reg <= 13'h0000;
         tick_reg <= 1'b0;
      end else if (tick_cnt_reg == 13'(TICK_CYCLES - 1)) begin
         tick_cnt_reg <= 13'h0000;
         tick_reg <= 1'b1;
      end else begin
         tick_cnt_reg <= tick_cnt_reg + 13'h0001;
         tick_reg <= 1'b0;
      end
   end

   // Short pulses; a retrigger restarts the width
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         done_cnt_reg <= 5'h00;
         relay_cnt_reg <= 5'h00;
      end else begin
         if (meas_done_evt)
            done_cnt_reg <= 5'(SHORT_CYCLES);
         else if (done_cnt_reg != 5'h00)
            done_cnt_reg <= done_cnt_reg - 5'h01;
         if (relay_closed_evt)
            relay_cnt_reg <= 5'(SHORT_CYCLES);
         else if (relay_cnt_reg != 5'h00)
            relay_cnt_reg <= relay_cnt_reg - 5'h01;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         measurement_done_out <= 1'b0;
         relay_closed_out <= 1'b0;
      end else begin
         measurement_done_out <= meas_done_evt || done_cnt_reg > 5'h01;
         relay_closed_out <= relay_closed_evt || relay_cnt_reg > 5'h01;
      end
   end

   // Interval timer: counts seconds of ticks
   assign interval_fire = interval_active && tick_reg &&
      sub_cnt_reg == 14'(TICKS_PER_SECOND - 1) &&
      sec_cnt_reg == sec_period_reg - 17'h00001;

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         interval_active <= 1'b0;
         sec_period_reg <= 17'h00001;
         sec_cnt_reg <= 17'h00000;
         sub_cnt_reg <= 14'h0000;
      end else if (cmd.interval_load) begin
         // Zero or out of range stops the timer
         interval_active <= hms_digits_ok && hms_secs != 20'h00000 &&
            hms_secs <= 20'(SEC_MAX);
         sec_period_reg <= hms_secs[16:0];
         sec_cnt_reg <= 17'h00000;
         sub_cnt_reg <= 14'h0000;
      end else if (cmd.interval_stop) begin
         interval_active <= 1'b0;
      end else if (interval_active && tick_reg) begin
         if (sub_cnt_reg == 14'(TICKS_PER_SECOND - 1)) begin
            sub_cnt_reg <= 14'h0000;
            sec_cnt_reg <= interval_fire ? 17'h00000 :
               sec_cnt_reg + 17'h00001;
         end else begin
            sub_cnt_reg <= sub_cnt_reg + 14'h0001;
         end
      end
   end

   // Fast timer: counts ticks
   assign fast_fire = fast_active && tick_reg &&
      fast_cnt_reg == fast_period_reg - 14'h0001;

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         fast_active <= 1'b0;
         fast_period_reg <= 14'h0001;
         fast_cnt_reg <= 14'h0000;
      end else if (cmd.fast_load) begin
         fast_active <= fast_timer_cmd != 14'h0 &&
            fast_timer_cmd <= 14'(FAST_MAX);
         fast_period_reg <= fast_timer_cmd;
         fast_cnt_reg <= 14'h0000;
      end else if (cmd.fast_stop) begin
         fast_active <= 1'b0;
      end else if (tick_reg && fast_active) begin
         fast_cnt_reg <= fast_fire ? 14'h0000 : fast_cnt_reg + 14'h0001;
      end
   end

   // Pulse widths; fast mode owns the output while active
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         iw_cnt_reg <= 12'h000;
         fw_cnt_reg <= 10'h000;
         timer_out <= 1'b0;
      end else begin
         if (interval_fire)
            iw_cnt_reg <= 12'(INTERVAL_W_CYCLES);
         else if (iw_cnt_reg != 12'h000)
            iw_cnt_reg <= iw_cnt_reg - 12'h001;
         if (fast_fire)
            fw_cnt_reg <= 10'(FAST_W_CYCLES);
         else if (fw_cnt_reg != 10'h000)
            fw_cnt_reg <= fw_cnt_reg - 10'h001;
         timer_out <= fast_active ? fw_cnt_reg != 10'h000 :
            iw_cnt_reg != 12'h000;
      end
   end

   // Service request; a new pulse wins over a clear
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         mask_reg <= 1'b0;
         service_request <= 1'b0;
      end else begin
         if (cmd.mask_load)
            mask_reg <= request_mask_set_cmd;
         if (interval_fire && mask_reg)
            service_request <= 1'b1;
         else if (request_clear)
            service_request <= 1'b0;
      end
   end

endmodule // tep_timer_ports
`default_nettype wire

//--- verilog/tep_pkg.sv
package tep_pkg;

   // Clock and time base
   localparam int unsigned CLK_HZ = 40_000_000;
   localparam real PULSE_SHORT_US = 0.5;
   localparam real PULSE_INTERVAL_US = 50.0;
   localparam real PULSE_FAST_US = 16.0;
   localparam real TICK_US = 100.0;
   localparam int unsigned TICK_CYC =
      int'($floor(TICK_US * CLK_HZ / 1.0e6));
   localparam int unsigned SHORT_CYC =
      int'($ceil(PULSE_SHORT_US * CLK_HZ / 1.0e6));
   localparam int unsigned INTERVAL_W_CYC =
      int'($ceil(PULSE_INTERVAL_US * CLK_HZ / 1.0e6));
   localparam int unsigned FAST_W_CYC =
      int'($ceil(PULSE_FAST_US * CLK_HZ / 1.0e6));
   localparam int unsigned TICKS_PER_SEC = 10_000;
   localparam int unsigned SEC_MAX = 86_400;
   localparam int unsigned FAST_MAX = 9_999;
   localparam logic [5:0] RESET_BCD_ZERO = 6'h00;

   // Interval setting, two BCD digits per field, hours first
   typedef struct packed {
      logic [7:0] hours;
      logic [7:0] minutes;
      logic [7:0] seconds;
   } tep_hms_type;

   // Command strobes from the command decoder
   typedef struct packed {
      logic interval_load;
      logic interval_stop;
      logic fast_load;
      logic fast_stop;
      logic mask_load;
   } tep_cmd_type;

   typedef enum logic [2:0] {
      TEP_IDLE = 3'b001,
      TEP_WAIT = 3'b010,
      TEP_HIGH = 3'b100
   } tep_state_type;

endpackage

//--- verification/tep_props.sv
`timescale 1ns/1ps
`default_nettype none
module tep_props
   import tep_pkg::*;
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire tep_cmd_type cmd,
   input wire tep_hms_type interval_hms,
   input wire logic [13:0] fast_timer_cmd,
   input wire logic request_clear,
   input wire logic measurement_done_out,
   input wire logic relay_closed_out,
   input wire logic timer_out,
   input wire logic service_request,
   input wire logic interval_active,
   input wire logic fast_active
);
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   // Pulse too long for a repetition, so count it
   int hi_cnt;
   always_ff @(posedge clk) hi_cnt <= timer_out ? hi_cnt + 1 : 0;
   chk_meas_width: assert property (
      $rose(measurement_done_out) |-> ##19 measurement_done_out ##1
      !measurement_done_out) else $error("done pulse width");
   chk_relay_width: assert property (
      $rose(relay_closed_out) |-> ##19 relay_closed_out ##1
      !relay_closed_out) else $error("relay pulse width");
   chk_fast_width: assert property (
      $fell(timer_out) && fast_active |-> hi_cnt == 640)
      else $error("fast pulse width");
   chk_fast_noreq: assert property (
      fast_active && !interval_active |-> !$rose(service_request))
      else $error("fast raised request");
   chk_first_wait: assert property (
      $rose(fast_active) |-> !timer_out [*8]) else $error("early pulse");
   chk_fast_range: assert property (
      cmd.fast_load && fast_timer_cmd > 14'h270F |=> !fast_active)
      else $error("fast count range");
   chk_hms_range: assert property (
      cmd.interval_load && interval_hms == 24'h240001 |=> !interval_active)
      else $error("interval range");
   chk_req_clear: assert property (
      request_clear && !interval_active |=> !service_request)
      else $error("request not cleared");
   chk_clear_drop: assert property (
      request_clear && !fast_active && !cmd.fast_load ##2
      !$rose(timer_out) |-> !$past(service_request))
      else $error("request not dropped");
   cover property ($rose(timer_out) && fast_active);
   cover property ($fell(relay_closed_out));
   cover property (fast_active && interval_active);
   cover property ($rose(service_request));
endmodule // tep_props
`default_nettype wire

//--- verification/tep_far_model.sv
`timescale 1ns/1ps
`default_nettype none
module tep_far_model (
   input wire logic clk,
   input wire logic timer_out,
   input wire logic service_request,
   output logic request_clear = 1'h0,
   output int pulses = 0
);
   logic last = 1'h0;
   // Controller answers one cycle late, like a polling host
   always @(posedge clk) begin
      request_clear <= service_request;
      last <= timer_out;
      if (timer_out && !last) pulses <= pulses + 1;
   end
endmodule // tep_far_model
`default_nettype wire

//--- verification/timer_and_event_pulse_ports_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module timer_and_event_pulse_ports_tb_top;
   import tep_pkg::*;
   logic clk = 0, sys_rst = 1, meas_done_evt = 0, relay_closed_evt = 0;
   logic request_mask_set_cmd = 1, request_clear;
   tep_cmd_type cmd = '0;
   tep_hms_type interval_hms = '0;
   logic [13:0] fast_timer_cmd = '0;
   logic measurement_done_out, relay_closed_out, timer_out;
   logic service_request, interval_active, fast_active;
   int pulses, fails = 0, check_count = 0, cyc = 0;
   // Short second keeps interval runs inside the cycle budget
   localparam int unsigned SIM_TICKS = 2;
   tep_timer_ports #(.TICKS_PER_SECOND(SIM_TICKS)) dut(.*);
   tep_far_model far(.*);
   always #12.5 clk = ~clk;
   always @(posedge clk) cyc <= cyc + 1;
   task automatic wrap_up;
      if (fails == 0 && check_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         fails++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic strobe(input logic [4:0] c, input logic [23:0] h,
         input logic [13:0] n);
      @(posedge clk) begin
         cmd <= tep_cmd_type'(c);
         interval_hms <= h;
         fast_timer_cmd <= n;
      end
      @(posedge clk) cmd <= '0;
      @(negedge clk);
   endtask
   task automatic rise(output int t);
      for (int i = 0; i < 9000 && timer_out !== 1'h1; i++) @(negedge clk);
      t = cyc;
   endtask
   task automatic width(output int w);
      for (w = 0; w < 2100 && timer_out === 1'h1; w++) @(negedge clk);
   endtask
   task automatic t_events;
      int n;
      for (int k = 0; k < 2; k++) begin
         @(posedge clk) {relay_closed_evt, meas_done_evt} <= k ? 2'h2 : 2'h1;
         @(posedge clk) {relay_closed_evt, meas_done_evt} <= 2'h0;
         n = 0;
         repeat (30) @(negedge clk)
            n += k ? relay_closed_out : measurement_done_out;
         chk(n, 20);
      end
   endtask
   task automatic t_fast;
      int t0, t1, t2, w;
      strobe(5'h05, 24'h000000, 14'h2710);
      chk(fast_active, 0);
      strobe(5'h05, 24'h000000, 14'h0002);
      t0 = cyc;
      chk(fast_active, 1);
      rise(t1);
      chk(t1 - t0 > 3999 && t1 - t0 < 8003, 1);
      w = 0;
      while (timer_out === 1'h1 && w < 700) begin
         @(negedge clk);
         w++;
      end
      chk(w, 640);
      rise(t2);
      chk(t2 - t1, 8000);
      @(negedge clk);
      chk(pulses, 2);
      chk(service_request, 0);
   endtask
   task automatic t_interval;
      strobe(5'h10, 24'h000001, 14'h0002);
      chk({interval_active, fast_active}, 2'h3);
      strobe(5'h10, 24'h240001, 14'h0002);
      chk(interval_active, 0);
      strobe(5'h10, 24'h240000, 14'h0002);
      chk(interval_active, 1);
      strobe(5'h0A, 24'h240000, 14'h0002);
      chk({interval_active, fast_active}, 2'h0);
   endtask
   task automatic t_request;
      int t0, t1, t2, t3, w;
      strobe(5'h10, 24'h000001, 14'h0000);
      t0 = cyc;
      rise(t1);
      chk(t1 - t0 > 3999 && t1 - t0 < 8003, 1);
      chk(service_request, 1);
      width(w);
      chk(w, INTERVAL_W_CYC);
      chk(service_request, 0);
      rise(t2);
      chk(t2 - t1, TICK_CYC * SIM_TICKS);
      chk(service_request, 1);
      width(w);
      @(posedge clk) request_mask_set_cmd <= 1'b0;
      strobe(5'h01, 24'h000000, 14'h0000);
      rise(t3);
      chk(t3 - t2, TICK_CYC * SIM_TICKS);
      chk(service_request, 0);
      width(w);
      chk(pulses, 5);
   endtask
   // Run is about 42000 cycles; margin for tick phase
   initial begin
      repeat (60000) @(posedge clk);
      fails++;
      wrap_up;
   end
   initial begin
      repeat (20) @(posedge clk);
      sys_rst <= 0;
      t_events;
      t_fast;
      t_interval;
      t_request;
      wrap_up;
   end
endmodule // timer_and_event_pulse_ports_tb_top
bind tep_timer_ports tep_props u_props(.*);
`default_nettype wire
